// ==== hip_consts.svh ====
// Offsets, field positions, reset values and sizes of the host index port block
`ifndef HIP_CONSTS_SVH
`define HIP_CONSTS_SVH
// ****************************************
// Register indices
// ****************************************
`define HIP_REG_TX_CONTROL 8'h02
`define HIP_REG_TX_STATUS_ONE 8'h03
`define HIP_REG_TX_STATUS_TWO 8'h04
`define HIP_REG_MRD_DUMMY 8'hF0
`define HIP_REG_MRD_INC 8'hF2
`define HIP_REG_RX_BASE_LO 8'hF4
`define HIP_REG_RX_BASE_HI 8'hF5
`define HIP_REG_MWR_NOINC 8'hF6
`define HIP_REG_MWR_INC 8'hF8
`define HIP_REG_MEM_ADDR_LO 8'hFA
`define HIP_REG_MEM_ADDR_HI 8'hFB
`define HIP_REG_TX_LENGTH_LO 8'hFC
`define HIP_REG_TX_LENGTH_HI 8'hFD
`define HIP_REG_INT_MASK 8'hFF
// ****************************************
// Field positions
// ****************************************
`define HIP_TXC_REQUEST 1
`define HIP_TXC_NO_CRC 2
`define HIP_TXC_NO_PAD 3
`define HIP_IMR_WRAP 7
// ****************************************
// Memory layout and reset values
// ****************************************
`define HIP_MEM_BYTES 16384
`define HIP_TX_END 14'h0C00
`define HIP_RX_BASE 14'h0C00
`define HIP_RX_SPAN 15'h3400
`define HIP_MEM_LAST 14'h3FFF
`define HIP_TX_START_RST 14'h0000
`define HIP_RX_MARKER 8'h01
`define HIP_RX_HDR_BYTES 3'h4
`define HIP_REG_RST 8'h00
`endif

// ==== hip_pkg.sv ====
// Types shared by the host index port block
package hip_pkg;
  typedef logic [13:0] hip_addr_t;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_DATA,
    RX_HDR
  } hip_rx_e;

  typedef struct packed {
    logic [7:0] index;
    logic [7:0] txCtrl;
    logic [7:0] txStatOne;
    logic [7:0] txStatTwo;
    logic [15:0] txLen;
    logic [7:0] intMask;
    hip_addr_t memAddr;
    logic [15:0] memBuf;
    logic prefetch;
    logic rdPrev;
    logic wrPrev;
    logic [15:0] dataOut;
    logic dataOe;
    logic txGo;
    logic txSlotTwo;
    hip_addr_t txStart;
  } hip_top_s;

  typedef struct packed {
    hip_rx_e st;
    hip_addr_t base;
    hip_addr_t ptr;
    logic [15:0] len;
    logic [7:0] status;
    logic [2:0] hdrIdx;
    logic wrEn;
    hip_addr_t wrAddr;
    logic [7:0] wrData;
  } hip_rx_s;
endpackage

// ==== hip_packet_mem.sv ====
// Packet memory with host, receive-write and transmit-read ports
`timescale 1ns/1ps
`include "hip_consts.svh"
module hip_packet_mem
  import hip_pkg::*;
#(
  parameter int DEPTH = `HIP_MEM_BYTES
) (
  input wire logic clk_sys,
  input wire logic hostWrEn,
  input wire logic hostWide,
  input wire hip_addr_t hostAddr,
  input wire logic [15:0] hostWrData,
  output logic [15:0] hostRdData,
  input wire logic rxWrEn,
  input wire hip_addr_t rxAddr,
  input wire logic [7:0] rxData,
  input wire hip_addr_t txAddr,
  output logic [7:0] txData
);
  logic [7:0] mem [DEPTH];
  hip_addr_t hostAddrNext;

  assign hostAddrNext = hostAddr + 14'h0001;
  // Asynchronous read so a prefetch lands one cycle after the address moves
  assign hostRdData = {mem[hostAddrNext], mem[hostAddr]};

  always_ff @(posedge clk_sys) begin
    if (rxWrEn) begin
      mem[rxAddr] <= rxData;
    end
    // Host write last: it wins a same-address collision
    if (hostWrEn) begin
      mem[hostAddr] <= hostWrData[7:0];
      if (hostWide) begin
        mem[hostAddrNext] <= hostWrData[15:8];
      end
    end
    txData <= mem[txAddr];
  end
endmodule

// ==== hip_rx_writer.sv ====
// Receive ring writer: frame bytes then the four-byte packet header
`timescale 1ns/1ps
`include "hip_consts.svh"
module hip_rx_writer
  import hip_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstN,
  input wire logic mode16,
  input wire logic rxValid,
  input wire logic [7:0] rxByte,
  input wire logic rxLast,
  input wire logic [7:0] rxStatus,
  output logic memWrEn,
  output hip_addr_t memAddr,
  output logic [7:0] memData,
  output hip_addr_t ringBase
);
  hip_rx_s s_q;
  hip_rx_s s_d;

  // Ring step: the last byte of memory is followed by the receive base
  function automatic hip_addr_t ringAdd(input hip_addr_t a, input logic [2:0] n);
    logic [14:0] sum;
    sum = {1'b0, a} + {12'h000, n};
    if (sum > {1'b0, `HIP_MEM_LAST}) begin
      sum = sum - `HIP_RX_SPAN;
    end
    return sum[13:0];
  endfunction

  assign memWrEn = s_q.wrEn;
  assign memAddr = s_q.wrAddr;
  assign memData = s_q.wrData;
  assign ringBase = s_q.base;

  always_comb begin
    s_d = s_q;
    s_d.wrEn = 1'b0;
    case (s_q.st)
      RX_IDLE, RX_DATA: begin
        if (rxValid) begin
          // R16 data after header
          s_d.wrEn = 1'b1;
          s_d.wrAddr = (s_q.st == RX_IDLE) ? ringAdd(s_q.base, `HIP_RX_HDR_BYTES) : s_q.ptr;
          s_d.wrData = rxByte;
          s_d.ptr = ringAdd(s_d.wrAddr, 3'h1);
          s_d.len = (s_q.st == RX_IDLE) ? 16'h0001 : s_q.len + 16'h0001;
          s_d.st = RX_DATA;
          if (rxLast) begin
            s_d.status = rxStatus;
            s_d.hdrIdx = 3'h0;
            s_d.st = RX_HDR;
          end
        end
      end
      RX_HDR: begin
        // R16 marker, status, length low, length high
        s_d.wrEn = 1'b1;
        s_d.wrAddr = ringAdd(s_q.base, s_q.hdrIdx);
        case (s_q.hdrIdx)
          3'h0: s_d.wrData = `HIP_RX_MARKER;
          3'h1: s_d.wrData = s_q.status;
          3'h2: s_d.wrData = s_q.len[7:0];
          default: s_d.wrData = s_q.len[15:8];
        endcase
        s_d.hdrIdx = s_q.hdrIdx + 3'h1;
        if (s_q.hdrIdx == 3'h3) begin
          s_d.st = RX_IDLE;
          // R17 next packet on a word boundary in 16-bit mode
          s_d.base = (mode16 && s_q.ptr[0]) ? ringAdd(s_q.ptr, 3'h1) : s_q.ptr;
        end
      end
      default: s_d.st = RX_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      s_q <= '0;
      s_q.st <= RX_IDLE;
      // R15 ring starts at the receive base
      s_q.base <= `HIP_RX_BASE;
      s_q.ptr <= `HIP_RX_BASE;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// ==== hip_host_port.sv ====
// Host index/data port with streaming packet memory access and transmit sequencing
`timescale 1ns/1ps
`include "hip_consts.svh"
// Overview of operation
// R1: Chip select is active low unless the loaded configuration makes it active high.
// R2: Port select low reaches the index port, high reaches the data port.
// R3: The index port value picks the register reached through the data port.
// R4: Host sets the memory address, then a dummy command loads the buffer.
// R5: Each memory command advances the address by bus width and prefetches; here only commands F2 and F8 advance, and only F0 and F2 prefetch.
// R6: Host discards data returned by the dummy access of a burst.
// R7: 16K bytes of memory: lowest 3K transmit, remaining 13K receive.
// R8: Write streaming with mask bit 7 wraps to zero at the 3K end.
// R9: Read streaming with mask bit 7 wraps to the receive base at 16K.
// R10: Two transmit packets may be held, used alternately as slot one and two.
// R11: Transmit control governs checksum and padding; each slot has its own status.
// R12: Reset sets transmit start address zero and selects slot one.
// R13: Data, then length registers, then control bit 1 starts the current slot.
// R14: Host waits for slot one to end before requesting slot two, then alternates.
// R15: Receive ring starts at the receive base after reset.
// R16: Each received packet has a marker, status, length low, length high header.
// R17: Each received packet starts on a boundary suited to the bus width.
// R18: The index port keeps its value until the host rewrites it.
// R19: Request bit clears when the slot finishes; the slot then alternates.
module hip_host_port
  import hip_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic csPin,
  input wire logic csActiveHigh,
  input wire logic cmdPin,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic mode16,
  input wire logic [15:0] dataIn,
  output logic [15:0] dataOut,
  output logic dataOe,
  output logic txGo,
  output logic txSlotTwo,
  output hip_addr_t txStartAddr,
  output logic [15:0] txLength,
  output logic txNoCrc,
  output logic txNoPad,
  input wire logic txDone,
  input wire logic [7:0] txDoneStatus,
  input wire hip_addr_t txRdAddr,
  output logic [7:0] txRdData,
  input wire logic rxValid,
  input wire logic [7:0] rxByte,
  input wire logic rxLast,
  input wire logic [7:0] rxStatus
);
  // ****************************************
  // Reset release
  // ****************************************
  logic rstMeta;
  logic rstN;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstN <= rstMeta;
    end
  end

  // ****************************************
  // Host strobes
  // ****************************************
  hip_top_s s_q;
  hip_top_s s_d;
  logic selected;
  logic rdAct;
  logic wrAct;
  logic rdStart;
  logic wrStart;
  logic [15:0] memRdData;
  logic memWrEn;
  logic [7:0] rxWrData;
  logic rxWrEn;
  hip_addr_t rxWrAddr;
  hip_addr_t rxBase;
  logic [7:0] regRd;
  hip_addr_t stepAddr;
  logic [16:0] txNext;

  // R1 select polarity from configuration
  assign selected = csActiveHigh ? csPin : ~csPin;
  assign rdAct = selected & ~rdN;
  assign wrAct = selected & ~wrN;
  // Act once per strobe, on its leading edge
  assign rdStart = rdAct & ~s_q.rdPrev;
  assign wrStart = wrAct & ~s_q.wrPrev;

  // ****************************************
  // Streaming address step
  // ****************************************
  // R5 step by bus width, R8 and R9 wrap when enabled
  function automatic hip_addr_t nextAddr(input hip_addr_t a, input logic wide,
                                         input logic isWrite, input logic wrapOn);
    logic [14:0] sum;
    sum = {1'b0, a} + (wide ? 15'h0002 : 15'h0001);
    if (wrapOn && isWrite && sum >= {1'b0, `HIP_TX_END}) begin
      // R8 transmit area wraps to location zero
      sum = 15'h0000;
    end else if (wrapOn && !isWrite && sum > {1'b0, `HIP_MEM_LAST}) begin
      // R9 receive area wraps to its base
      sum = {1'b0, `HIP_RX_BASE};
    end
    return sum[13:0];
  endfunction

  assign stepAddr = nextAddr(s_q.memAddr, mode16,
                             (s_q.index == `HIP_REG_MWR_INC), s_q.intMask[`HIP_IMR_WRAP]);
  // R10 next slot starts where the sent packet ended, inside the transmit area
  assign txNext = {3'b000, s_q.txStart} + {1'b0, s_q.txLen};

  // ****************************************
  // Register read mux
  // ****************************************
  always_comb begin
    // R3 index selects the register
    case (s_q.index)
      `HIP_REG_TX_CONTROL: regRd = s_q.txCtrl;
      `HIP_REG_TX_STATUS_ONE: regRd = s_q.txStatOne;
      `HIP_REG_TX_STATUS_TWO: regRd = s_q.txStatTwo;
      `HIP_REG_TX_LENGTH_LO: regRd = s_q.txLen[7:0];
      `HIP_REG_TX_LENGTH_HI: regRd = s_q.txLen[15:8];
      `HIP_REG_INT_MASK: regRd = s_q.intMask;
      `HIP_REG_MEM_ADDR_LO: regRd = s_q.memAddr[7:0];
      `HIP_REG_MEM_ADDR_HI: regRd = {2'b00, s_q.memAddr[13:8]};
      `HIP_REG_RX_BASE_LO: regRd = rxBase[7:0];
      `HIP_REG_RX_BASE_HI: regRd = {2'b00, rxBase[13:8]};
      default: regRd = 8'h00;
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.rdPrev = rdAct;
    s_d.wrPrev = wrAct;
    s_d.txGo = 1'b0;
    s_d.prefetch = 1'b0;
    // Drive the bus only while a read strobe is on us
    s_d.dataOe = rdAct;
    if (!rdAct) begin
      s_d.dataOut = 16'h0000;
    end
    // Prefetched word lands one cycle after the address moves
    if (s_q.prefetch) begin
      s_d.memBuf = memRdData;
    end

    // R2 port select: index or data
    if (rdStart) begin
      if (!cmdPin) begin
        s_d.dataOut = {8'h00, s_q.index};
      end else if (s_q.index == `HIP_REG_MRD_DUMMY) begin
        // R4 dummy read returns stale buffer and loads current location
        s_d.dataOut = mode16 ? s_q.memBuf : {8'h00, s_q.memBuf[7:0]};
        s_d.prefetch = 1'b1;
      end else if (s_q.index == `HIP_REG_MRD_INC) begin
        // R5 return buffer, advance, prefetch
        s_d.dataOut = mode16 ? s_q.memBuf : {8'h00, s_q.memBuf[7:0]};
        s_d.memAddr = stepAddr;
        s_d.prefetch = 1'b1;
      end else begin
        s_d.dataOut = {8'h00, regRd};
      end
    end

    if (wrStart) begin
      if (!cmdPin) begin
        // R18 index held until rewritten
        s_d.index = dataIn[7:0];
      end else begin
        case (s_q.index)
          `HIP_REG_TX_CONTROL: begin
            // R11 checksum and pad controls
            s_d.txCtrl[`HIP_TXC_NO_CRC] = dataIn[`HIP_TXC_NO_CRC];
            s_d.txCtrl[`HIP_TXC_NO_PAD] = dataIn[`HIP_TXC_NO_PAD];
            // R13 request starts the current slot
            if (dataIn[`HIP_TXC_REQUEST] && !s_q.txCtrl[`HIP_TXC_REQUEST]) begin
              s_d.txCtrl[`HIP_TXC_REQUEST] = 1'b1;
              s_d.txGo = 1'b1;
            end
          end
          `HIP_REG_TX_LENGTH_LO: s_d.txLen[7:0] = dataIn[7:0];
          `HIP_REG_TX_LENGTH_HI: s_d.txLen[15:8] = dataIn[7:0];
          `HIP_REG_INT_MASK: s_d.intMask = dataIn[7:0];
          `HIP_REG_MEM_ADDR_LO: begin
            s_d.memAddr[7:0] = dataIn[7:0];
          end
          `HIP_REG_MEM_ADDR_HI: begin
            s_d.memAddr[13:8] = dataIn[5:0];
          end
          `HIP_REG_MWR_INC: begin
            // R5 write then advance
            s_d.memAddr = stepAddr;
          end
          default: begin
          end
        endcase
      end
    end

    // R19 completion clears the request and alternates the slot
    if (txDone) begin
      if (s_q.txSlotTwo) begin
        s_d.txStatTwo = txDoneStatus;
      end else begin
        s_d.txStatOne = txDoneStatus;
      end
      s_d.txCtrl[`HIP_TXC_REQUEST] = 1'b0;
      s_d.txSlotTwo = ~s_q.txSlotTwo;
      // Full modulo: any programmed length still lands inside the transmit area
      s_d.txStart = 14'(txNext % {3'b000, `HIP_TX_END});
    end
  end

  // Memory write on the leading edge of a data-port write to a write command
  assign memWrEn = wrStart & cmdPin &
                   ((s_q.index == `HIP_REG_MWR_INC) | (s_q.index == `HIP_REG_MWR_NOINC));

  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      s_q <= '0;
      s_q.index <= `HIP_REG_RST;
      s_q.txCtrl <= `HIP_REG_RST;
      // R12 transmit start zero, slot one current
      s_q.txStart <= `HIP_TX_START_RST;
      s_q.txSlotTwo <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dataOut = s_q.dataOut;
  assign dataOe = s_q.dataOe;
  assign txGo = s_q.txGo;
  assign txSlotTwo = s_q.txSlotTwo;
  assign txStartAddr = s_q.txStart;
  assign txLength = s_q.txLen;
  assign txNoCrc = s_q.txCtrl[`HIP_TXC_NO_CRC];
  assign txNoPad = s_q.txCtrl[`HIP_TXC_NO_PAD];

  // ****************************************
  // Packet memory and receive ring
  // ****************************************
  // R7 16K bytes split into transmit and receive areas
  hip_packet_mem #(
    .DEPTH(`HIP_MEM_BYTES)
  ) u_mem (
    .clk_sys(clk_sys),
    .hostWrEn(memWrEn),
    .hostWide(mode16),
    .hostAddr(s_q.memAddr),
    .hostWrData(dataIn),
    .hostRdData(memRdData),
    .rxWrEn(rxWrEn),
    .rxAddr(rxWrAddr),
    .rxData(rxWrData),
    .txAddr(txRdAddr),
    .txData(txRdData)
  );

  hip_rx_writer u_rx (
    .clk_sys(clk_sys),
    .rstN(rstN),
    .mode16(mode16),
    .rxValid(rxValid),
    .rxByte(rxByte),
    .rxLast(rxLast),
    .rxStatus(rxStatus),
    .memWrEn(rxWrEn),
    .memAddr(rxWrAddr),
    .memData(rxWrData),
    .ringBase(rxBase)
  );
endmodule

// ==== hip_host_port_assertions.sv ====
// Concurrent checks on the host port pins
`timescale 1ns/1ps
module hip_host_checker
  import hip_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic csPin,
  input wire logic csActiveHigh,
  input wire logic cmdPin,
  input wire logic rdN,
  input wire logic wrN,
  input wire logic [15:0] dataIn,
  input wire logic [15:0] dataOut,
  input wire logic dataOe,
  input wire logic txGo,
  input wire logic txSlotTwo,
  input wire hip_addr_t txStartAddr,
  input wire logic [15:0] txLength,
  input wire logic txDone
);
  logic wrOn_q;
  logic rdOn_q;
  logic pend_q;
  logic [7:0] idx_q;
  logic selOn;
  logic wrOn;
  logic rdOn;
  logic reqNow;
  assign selOn = csActiveHigh ? csPin : !csPin;
  assign wrOn = selOn && !wrN;
  assign rdOn = selOn && !rdN;
  // Only a fresh write of bit 1 with no request pending counts
  assign reqNow = wrOn && !wrOn_q && cmdPin && idx_q == 8'h02 && dataIn[1] && !pend_q;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wrOn_q <= 1'b0;
      rdOn_q <= 1'b0;
      pend_q <= 1'b0;
      idx_q <= 8'h00;
    end else begin
      wrOn_q <= wrOn;
      rdOn_q <= rdOn;
      pend_q <= txGo ? 1'b1 : (txDone ? 1'b0 : pend_q);
      if (wrOn && !wrOn_q && !cmdPin) begin
        idx_q <= dataIn[7:0];
      end
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence sReadTaken;
    rdOn && !rdOn_q;
  endsequence
  sequence sSlotDone;
    txDone && pend_q;
  endsequence
  req_starts_go_a: assert property (reqNow |=> txGo)
    else $error("request gave no start pulse");
  go_has_cause_a: assert property (txGo |-> $past(reqNow))
    else $error("start pulse without request");
  go_one_cycle_a: assert property (txGo |=> !txGo)
    else $error("start pulse too long");
  pend_no_go_a: assert property (pend_q |-> !txGo)
    else $error("second start while busy");
  read_answer_a: assert property (sReadTaken |=> dataOe)
    else $error("read not answered");
  oe_needs_read_a: assert property (dataOe |-> $past(rdOn))
    else $error("bus driven without read");
  idle_zero_a: assert property (!dataOe |-> dataOut == 16'h0000)
    else $error("read data not cleared");
  slot_flip_a: assert property (sSlotDone |=> txSlotTwo != $past(txSlotTwo))
    else $error("slot did not alternate");
  slot_hold_a: assert property (!txDone |=> $stable(txSlotTwo))
    else $error("slot moved without completion");
  start_next_a: assert property (sSlotDone |=> 32'(txStartAddr) ==
    (32'($past(txStartAddr)) + 32'($past(txLength))) % 32'h0000_0C00)
    else $error("next start address wrong");
endmodule
bind hip_host_port hip_host_checker chk (.clk_sys(clk_sys), .arst_n(arst_n), .csPin(csPin),
  .csActiveHigh(csActiveHigh), .cmdPin(cmdPin), .rdN(rdN), .wrN(wrN), .dataIn(dataIn),
  .dataOut(dataOut), .dataOe(dataOe), .txGo(txGo), .txSlotTwo(txSlotTwo),
  .txStartAddr(txStartAddr), .txLength(txLength), .txDone(txDone));

// ==== hip_host_model.sv ====
// Processor model making one host bus access at a time
`timescale 1ns/1ps
module hip_host_model (
  input wire logic clk_sys,
  input wire logic csActiveHigh,
  input wire logic [15:0] dataOut,
  output logic csPin,
  output logic cmdPin,
  output logic rdN,
  output logic wrN,
  output logic [15:0] dataIn
);
  int slow = 0;
  initial begin
    csPin = 1'b1;
    cmdPin = 1'b0;
    rdN = 1'b1;
    wrN = 1'b1;
    dataIn = 16'h0000;
  end
  // strobe held until the answer, then one idle cycle; bad picks the wrong level
  task automatic access(input logic cmd, input logic wr, input logic [15:0] wd,
                        input logic bad, output logic [15:0] rd);
    csPin = csActiveHigh ^ bad;
    cmdPin = cmd;
    dataIn = wd;
    wrN = !wr;
    rdN = wr;
    repeat (2 + slow) @(posedge clk_sys);
    #1 rd = dataOut;
    csPin = !csActiveHigh;
    wrN = 1'b1;
    rdN = 1'b1;
    // Released lines show a changed pattern, never the old value
    dataIn = ~wd;
    cmdPin = !cmd;
    @(posedge clk_sys);
    #1;
  endtask
endmodule

// ==== hip_host_port_bench.sv ====
// Self-checking bench of the host index port block
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
module hip_host_port_bench import hip_pkg::*;;
  logic clk_sys, arst_n, csActiveHigh, mode16, txDone, rxValid, rxLast, wrapOn;
  logic csPin, cmdPin, rdN, wrN, dataOe, txGo, txSlotTwo, txNoCrc, txNoPad;
  logic [15:0] dataIn, dataOut, txLength, v, w, ln;
  logic [7:0] txDoneStatus, rxByte, rxStatus, txRdData, st;
  logic [7:0] refMem [0:16383];
  hip_addr_t txStartAddr, txRdAddr, a, base, start;
  int n_errors = 0, checks_done = 0, seed = 22, gos = 0, n;
  hip_host_port dut (.clk_sys(clk_sys), .arst_n(arst_n), .csPin(csPin),
    .csActiveHigh(csActiveHigh), .cmdPin(cmdPin), .rdN(rdN), .wrN(wrN), .mode16(mode16),
    .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .txGo(txGo), .txSlotTwo(txSlotTwo),
    .txStartAddr(txStartAddr), .txLength(txLength), .txNoCrc(txNoCrc), .txNoPad(txNoPad),
    .txDone(txDone), .txDoneStatus(txDoneStatus), .txRdAddr(txRdAddr), .txRdData(txRdData),
    .rxValid(rxValid), .rxByte(rxByte), .rxLast(rxLast), .rxStatus(rxStatus));
  hip_host_model host (.clk_sys(clk_sys), .csActiveHigh(csActiveHigh), .dataOut(dataOut),
    .csPin(csPin), .cmdPin(cmdPin), .rdN(rdN), .wrN(wrN), .dataIn(dataIn));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (txGo === 1'b1) gos++;
  end
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk_sys);
    n_errors++;
    end_of_test();
  end
  function automatic hip_addr_t stepAddr(hip_addr_t p, logic isWr);
    logic [14:0] s;
    s = 15'(p) + (mode16 ? 15'h0002 : 15'h0001);
    if (wrapOn && isWr && s >= 15'h0C00) return 14'h0000;
    if (wrapOn && !isWr && s > 15'h3FFF) return 14'h0C00;
    return s[13:0];
  endfunction
  task automatic setReg(input logic [7:0] ix, input logic [15:0] val);
    logic [15:0] d;
    host.access(1'b0, 1'b1, {8'h00, ix}, 1'b0, d);
    host.access(1'b1, 1'b1, val, 1'b0, d);
  endtask
  task automatic getReg(input logic [7:0] ix, output logic [15:0] val);
    logic [15:0] d;
    host.access(1'b0, 1'b1, {8'h00, ix}, 1'b0, d);
    host.access(1'b1, 1'b0, 16'h0000, 1'b0, val);
  endtask
  task automatic setAddr(input hip_addr_t p);
    setReg(8'hFA, {8'h00, p[7:0]});
    setReg(8'hFB, {10'h000, p[13:8]});
  endtask
  task automatic memWrite(input hip_addr_t p, input int cnt);
    logic [15:0] d;
    setAddr(p);
    host.access(1'b0, 1'b1, 16'h00F8, 1'b0, d);
    for (int i = 0; i < cnt; i++) begin
      v = 16'($random(seed));
      host.access(1'b1, 1'b1, v, 1'b0, d);
      refMem[p] = v[7:0];
      if (mode16) refMem[14'(p + 14'h0001)] = v[15:8];
      p = stepAddr(p, 1'b1);
    end
  endtask
  task automatic memCheck(input hip_addr_t p, input int cnt);
    logic [15:0] d;
    logic [15:0] m;
    m = mode16 ? 16'hFFFF : 16'h00FF;
    setAddr(p);
    getReg(8'hF0, d);
    host.access(1'b0, 1'b1, 16'h00F2, 1'b0, d);
    for (int i = 0; i < cnt; i++) begin
      host.access(1'b1, 1'b0, 16'h0000, 1'b0, d);
      `CHK(d & m, {refMem[14'(p + 14'h0001)], refMem[p]} & m)
      p = stepAddr(p, 1'b0);
    end
  endtask
  initial begin
    arst_n = 1'b0;
    {csActiveHigh, mode16, wrapOn, txDone, rxValid, rxLast} = 6'h00;
    {txDoneStatus, rxByte, rxStatus} = 24'h00_0000;
    txRdAddr = 14'h0000;
    repeat (12) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK({txSlotTwo, txGo, dataOe, txNoCrc, txNoPad, txStartAddr, txLength}, 35'h0_0000_0000)
    getReg(8'hF4, v);
    getReg(8'hF5, w);
    `CHK({w[7:0], v[7:0]}, 16'h0C00)
    getReg(8'h40, v);
    `CHK(v, 16'h0000)
    setReg(8'hFC, 16'h00C3);
    setReg(8'hFD, 16'h0012);
    host.access(1'b1, 1'b0, 16'h0000, 1'b0, v);
    `CHK(v[7:0], 8'h12)
    `CHK(txLength, 16'h12C3)
    host.access(1'b0, 1'b0, 16'h0000, 1'b0, v);
    `CHK(v, 16'h00FD)
    for (int m = 0; m < 2; m++) begin
      mode16 = m[0];
      a = 14'($random(seed)) & 14'h07FE;
      memWrite(a, 6);
      memCheck(a, 6);
      txRdAddr = a;
      repeat (2) @(posedge clk_sys);
      #1 `CHK(txRdData, refMem[a])
    end
    w = 16'($random(seed));
    setAddr(14'h0100);
    host.access(1'b0, 1'b1, 16'h00F6, 1'b0, v);
    host.access(1'b1, 1'b1, ~w, 1'b0, v);
    host.access(1'b1, 1'b1, w, 1'b0, v);
    {refMem[14'h0101], refMem[14'h0100]} = w;
    getReg(8'hFA, v);
    `CHK(v[7:0], 8'h00)
    memCheck(14'h0100, 1);
    for (int f = 0; f < 2; f++) begin
      mode16 = !f[0];
      n = f ? 5 : 7;
      base = f ? 14'h0C0C : 14'h0C00;
      st = 8'($random(seed));
      for (int i = 0; i < n; i++) begin
        {rxValid, rxLast, rxStatus} = {1'b1, i == n - 1, st};
        rxByte = 8'($random(seed));
        refMem[base + 4 + i] = rxByte;
        @(posedge clk_sys);
        #1;
      end
      {rxValid, rxLast} = 2'h0;
      repeat (6) @(posedge clk_sys);
      #1;
      {refMem[base], refMem[base + 1], refMem[base + 2], refMem[base + 3]} = {8'h01, st, 8'(n), 8'h00};
      getReg(8'hF4, v);
      getReg(8'hF5, w);
      `CHK({w[5:0], v[7:0]}, f ? 14'h0C15 : 14'h0C0C)
      memCheck(base, f ? 9 : 5);
    end
    host.slow = 1;
    mode16 = 1'b0;
    wrapOn = 1'b1;
    setReg(8'hFF, 16'h0080);
    memWrite(14'h0BFE, 4);
    memCheck(14'h0000, 2);
    wrapOn = 1'b0;
    setReg(8'hFF, 16'h0000);
    memWrite(14'h3FFE, 2);
    wrapOn = 1'b1;
    setReg(8'hFF, 16'h0080);
    memCheck(14'h3FFE, 4);
    host.slow = 0;
    start = 14'h0000;
    for (int s = 0; s < 2; s++) begin
      ln = 16'($random(seed)) & 16'h07FF;
      setReg(8'hFC, {8'h00, ln[7:0]});
      setReg(8'hFD, {8'h00, ln[15:8]});
      gos = 0;
      setReg(8'h02, s ? 16'h000A : 16'h0006);
      `CHK({txNoPad, txNoCrc, txSlotTwo, txLength}, {s[0], !s[0], s[0], ln})
      `CHK(txStartAddr, start)
      setReg(8'h02, 16'h0002);
      `CHK(gos, 1)
      getReg(8'h02, v);
      `CHK(v[1], 1'b1)
      st = 8'($random(seed));
      txDoneStatus = st;
      // next request only after this slot ends
      txDone = 1'b1;
      @(posedge clk_sys);
      #1 txDone = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      start = 14'((32'(start) + 32'(ln)) % 32'h0000_0C00);
      `CHK({txSlotTwo, txStartAddr}, {!s[0], start})
      setReg(s ? 8'h04 : 8'h03, {8'h00, ~st});
      getReg(s ? 8'h04 : 8'h03, v);
      `CHK(v[7:0], st)
      getReg(8'h02, v);
      `CHK(v[1], 1'b0)
    end
    csActiveHigh = 1'b1;
    setReg(8'hFC, 16'h00A5);
    host.access(1'b1, 1'b1, 16'h005A, 1'b1, v);
    `CHK(txLength[7:0], 8'hA5)
    end_of_test();
  end
endmodule
